// >>> core/sto_pkg.sv
// shared constants and types for the dual channel safe torque off block
package sto_pkg;

    // clock and timing
    localparam int CLK_KHZ        = 25000;
    localparam int RESP_MS        = 20;
    localparam int RESP_CYCLES    = RESP_MS * CLK_KHZ;
    localparam int SWITCH_MS      = 200;
    localparam int SWITCH_CYCLES  = SWITCH_MS * CLK_KHZ;
    localparam int CNT_W          = 24;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_STATUS    = 8'h04;
    localparam logic [7:0] OFS_FAULT_ST  = 8'h08;
    localparam logic [7:0] OFS_INT_STAT  = 8'h0C;
    localparam logic [7:0] OFS_INT_MASK  = 8'h10;

    // control register fields
    localparam int CTRL_AUTO_CLR_BIT  = 0;
    localparam int CTRL_FAULT_RST_BIT = 1;
    localparam logic CTRL_AUTO_CLR_RST = 1'b1;

    // channel fault state fields
    localparam int FST_CHAN_A_BIT = 0;
    localparam int FST_CHAN_B_BIT = 4;

    // status register fields
    localparam int STS_STATE_LSB  = 0;
    localparam int STS_IN_A_BIT   = 2;
    localparam int STS_IN_B_BIT   = 3;
    localparam int STS_READY_BIT  = 4;
    localparam int STS_TO_BIT     = 5;
    localparam int STS_FA_BIT     = 6;
    localparam int STS_FB_BIT     = 7;
    localparam int STS_FC_BIT     = 8;
    localparam int STS_WAIT_BIT   = 9;

    // interrupt events
    localparam int EV_W           = 4;
    localparam int EV_TORQUE_OFF  = 0;
    localparam int EV_CHAN_A      = 1;
    localparam int EV_CHAN_B      = 2;
    localparam int EV_CIRCUIT     = 3;
    localparam logic [EV_W-1:0] INT_MASK_RST = 4'h0;

    typedef enum logic [1:0] {
        ST_RUN        = 2'b00,
        ST_DISCREP    = 2'b01,
        ST_TORQUE_OFF = 2'b11,
        ST_FAULT      = 2'b10
    } sto_state_e;

    // apb request group
    typedef struct packed {
        logic       psel;
        logic       penable;
        logic       pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } sto_apb_req_s;

endpackage : sto_pkg

// >>> core/sto_core.sv
// dual channel safe torque off interlock with apb register slave
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ns
module sto_core
    import sto_pkg::*;
#(
    parameter int PWM_W     = 6,
    parameter int DISC_CYC  = SWITCH_CYCLES
)(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             safe_off_input_a,
    input  wire logic             safe_off_input_b,
    input  wire logic             circuit_fault_in,
    input  wire logic [PWM_W-1:0] pwm_gate_in,
    output logic      [PWM_W-1:0] pwm_gate_out,
    output logic                  drive_ready,
    output logic                  coast_stop,
    output logic                  torque_off_indication,
    output logic                  channel_a_fault_code,
    output logic                  channel_b_fault_code,
    output logic                  circuit_fault_code,
    output logic                  irq
);

    typedef struct packed {
        logic             a_meta;
        logic             a_sync;
        logic             b_meta;
        logic             b_sync;
        logic             c_meta;
        logic             c_sync;
        sto_state_e       st;
        logic [CNT_W-1:0] cnt;
        logic             seen_a;
        logic             seen_b;
        logic             flt_a;
        logic             flt_b;
        logic             flt_c;
        logic             auto_clr;
        logic [EV_W-1:0]  int_stat;
        logic [EV_W-1:0]  int_mask;
        logic [PWM_W-1:0] gate;
        logic             ready;
        logic             coast;
        logic             ind_to;
        logic             irq;
        logic             pready;
        logic             pslverr;
        logic [31:0]      prdata;
    } sto_regs_s;

    sto_regs_s    st_r;
    sto_regs_s    st_nxt;
    sto_apb_req_s req;

    // true when the byte address hits a mapped register
    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_FAULT_ST)
                || (a == OFS_INT_STAT) || (a == OFS_INT_MASK);
    endfunction : addr_hit

    assign req.psel    = psel;
    assign req.penable = penable;
    assign req.pwrite  = pwrite;
    assign req.paddr   = paddr;
    assign req.pwdata  = pwdata;

    logic            both_high;
    logic            both_low;
    logic            wr_acc;
    logic            fault_rst;
    logic [EV_W-1:0] ev;
    logic [31:0]     rd;

    always_comb
    begin
        st_nxt = st_r;
        ev     = '0;

        // synchronisers; only the second stage is read below
        st_nxt.a_meta = safe_off_input_a;
        st_nxt.a_sync = st_r.a_meta;
        st_nxt.b_meta = safe_off_input_b;
        st_nxt.b_sync = st_r.b_meta;
        st_nxt.c_meta = circuit_fault_in;
        st_nxt.c_sync = st_r.c_meta;

        both_high = st_r.a_sync && st_r.b_sync;
        both_low  = !st_r.a_sync && !st_r.b_sync;

        wr_acc    = req.psel && req.penable && st_r.pready && req.pwrite && !st_r.pslverr;
        fault_rst = wr_acc && (req.paddr == OFS_CTRL) && req.pwdata[CTRL_FAULT_RST_BIT];

        // classification
        unique case (st_r.st)
            ST_RUN:
            begin
                if (both_low)
                begin
                    st_nxt.st = ST_TORQUE_OFF;
                    ev[EV_TORQUE_OFF] = 1'b1;
                end
                else if (!both_high)
                begin
                    st_nxt.st     = ST_DISCREP;
                    st_nxt.cnt    = '0;
                    st_nxt.seen_a = !st_r.a_sync;
                    st_nxt.seen_b = !st_r.b_sync;
                end
            end
            ST_DISCREP:
            begin
                // give the partner switch its transition time before calling it one channel
                st_nxt.cnt    = st_r.cnt + 1'b1;
                st_nxt.seen_a = st_r.seen_a || !st_r.a_sync;
                st_nxt.seen_b = st_r.seen_b || !st_r.b_sync;
                if (both_low)
                begin
                    st_nxt.st = ST_TORQUE_OFF;
                    ev[EV_TORQUE_OFF] = 1'b1;
                end
                else if (st_r.cnt >= CNT_W'(DISC_CYC - 1) || both_high)
                begin
                    st_nxt.st    = ST_FAULT;
                    st_nxt.flt_a = st_nxt.seen_a;
                    st_nxt.flt_b = st_nxt.seen_b;
                    ev[EV_CHAN_A] = st_nxt.seen_a;
                    ev[EV_CHAN_B] = st_nxt.seen_b;
                end
            end
            ST_TORQUE_OFF:
            begin
                if (both_high && (st_r.auto_clr || fault_rst))
                begin
                    st_nxt.st = ST_RUN;
                end
            end
            ST_FAULT:
            begin
                if (fault_rst && both_high && !st_r.c_sync)
                begin
                    st_nxt.st    = ST_RUN;
                    st_nxt.flt_a = 1'b0;
                    st_nxt.flt_b = 1'b0;
                    st_nxt.flt_c = 1'b0;
                end
            end
        endcase

        // a circuit fault overrides every other state
        if (st_r.c_sync)
        begin
            st_nxt.st    = ST_FAULT;
            st_nxt.flt_c = 1'b1;
            ev[EV_CIRCUIT] = !st_r.flt_c;
        end

        // output stage: gates follow the next state so a forced fault blocks them at once
        st_nxt.ready  = both_high && (st_nxt.st == ST_RUN);
        st_nxt.gate   = st_nxt.ready ? pwm_gate_in : '0;
        st_nxt.coast  = !st_nxt.ready;
        st_nxt.ind_to = (st_nxt.st == ST_TORQUE_OFF);

        // interrupts; a new event wins over a write-one clear
        st_nxt.int_stat = st_r.int_stat | ev;
        if (wr_acc && req.paddr == OFS_INT_STAT)
        begin
            st_nxt.int_stat = (st_r.int_stat & ~req.pwdata[EV_W-1:0]) | ev;
        end
        if (wr_acc && req.paddr == OFS_INT_MASK)
        begin
            st_nxt.int_mask = req.pwdata[EV_W-1:0];
        end
        if (wr_acc && req.paddr == OFS_CTRL)
        begin
            st_nxt.auto_clr = req.pwdata[CTRL_AUTO_CLR_BIT];
        end
        st_nxt.irq = |(st_nxt.int_stat & st_nxt.int_mask);

        // read mux
        rd = '0;
        unique case (req.paddr)
            OFS_CTRL:     rd[CTRL_AUTO_CLR_BIT] = st_r.auto_clr;
            OFS_STATUS:
            begin
                rd[STS_STATE_LSB +: 2] = st_r.st;
                rd[STS_IN_A_BIT]       = st_r.a_sync;
                rd[STS_IN_B_BIT]       = st_r.b_sync;
                rd[STS_READY_BIT]      = st_r.ready;
                rd[STS_TO_BIT]         = st_r.ind_to;
                rd[STS_FA_BIT]         = st_r.flt_a;
                rd[STS_FB_BIT]         = st_r.flt_b;
                rd[STS_FC_BIT]         = st_r.flt_c;
                rd[STS_WAIT_BIT]       = (st_r.st == ST_DISCREP);
            end
            OFS_FAULT_ST:
            begin
                rd[FST_CHAN_A_BIT] = st_r.flt_a;
                rd[FST_CHAN_B_BIT] = st_r.flt_b;
            end
            OFS_INT_STAT: rd[EV_W-1:0] = st_r.int_stat;
            OFS_INT_MASK: rd[EV_W-1:0] = st_r.int_mask;
            default:      rd = '0;
        endcase

        // apb: answer in the first access cycle, no wait states
        st_nxt.pready  = 1'b0;
        st_nxt.pslverr = 1'b0;
        if (req.psel && !req.penable)
        begin
            st_nxt.pready  = 1'b1;
            st_nxt.pslverr = !addr_hit(req.paddr);
            st_nxt.prdata  = (!req.pwrite && addr_hit(req.paddr)) ? rd : '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r          <= '0;
            st_r.st       <= ST_FAULT;
            st_r.coast    <= 1'b1;
            st_r.auto_clr <= CTRL_AUTO_CLR_RST;
            st_r.int_mask <= INT_MASK_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign prdata                = st_r.prdata;
    assign pready                = st_r.pready;
    assign pslverr               = st_r.pslverr;
    assign pwm_gate_out          = st_r.gate;
    assign drive_ready           = st_r.ready;
    assign coast_stop            = st_r.coast;
    assign torque_off_indication = st_r.ind_to;
    assign channel_a_fault_code  = st_r.flt_a;
    assign channel_b_fault_code  = st_r.flt_b;
    assign circuit_fault_code    = st_r.flt_c;
    assign irq                   = st_r.irq;

endmodule : sto_core

// >>> sim/sto_core_monitor.sv
// concurrent checks on the safe torque off core ports
`timescale 1ns/1ns
module sto_core_monitor
    import sto_pkg::*;
#(
    parameter int PWM_W = 6
)(
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             safe_off_input_a,
    input wire logic             safe_off_input_b,
    input wire logic             circuit_fault_in,
    input wire logic [PWM_W-1:0] pwm_gate_out,
    input wire logic             drive_ready,
    input wire logic             coast_stop,
    input wire logic             torque_off_indication,
    input wire logic             channel_a_fault_code,
    input wire logic             channel_b_fault_code,
    input wire logic             circuit_fault_code
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    gate_block_a: assert property (!safe_off_input_a |-> ##3 pwm_gate_out == '0)
        else $error("gates pass after input a dropped");
    gate_block_b_a: assert property (!safe_off_input_b |-> ##3 pwm_gate_out == '0)
        else $error("gates pass after input b dropped");
    ready_gates_a: assert property (!drive_ready |-> pwm_gate_out == '0)
        else $error("gates pass while not ready");
    coast_inv_a: assert property (coast_stop != drive_ready)
        else $error("coast not inverse of ready");
    run_needs_a: assert property (drive_ready |-> $past(safe_off_input_a, 3) && $past(safe_off_input_b, 3))
        else $error("ready without both inputs high");
    circuit_stop_a: assert property (circuit_fault_in |-> ##3 circuit_fault_code && !drive_ready)
        else $error("circuit fault not reported");
    torque_code_a: assert property (torque_off_indication |-> !drive_ready && !circuit_fault_code)
        else $error("torque off with ready or circuit code");
    fault_hold_a: assert property (!safe_off_input_a ##1 channel_a_fault_code |=> channel_a_fault_code)
        else $error("channel a fault cleared while input low");

    cover property ($rose(torque_off_indication));
    cover property ($rose(channel_a_fault_code));
    cover property ($rose(circuit_fault_code));
endmodule : sto_core_monitor

bind sto_core sto_core_monitor #(.PWM_W(PWM_W)) u_mon (
    .pclk(pclk), .presetn(presetn), .safe_off_input_a(safe_off_input_a),
    .safe_off_input_b(safe_off_input_b), .circuit_fault_in(circuit_fault_in), .pwm_gate_out(pwm_gate_out),
    .drive_ready(drive_ready), .coast_stop(coast_stop), .torque_off_indication(torque_off_indication),
    .channel_a_fault_code(channel_a_fault_code), .channel_b_fault_code(channel_b_fault_code),
    .circuit_fault_code(circuit_fault_code));

// >>> sim/sto_switch_model.sv
// behavioural safety switch driving both safe-off inputs
`timescale 1ns/1ns
module sto_switch_model #(
    parameter int SW_DLY = 3
)(
    input  wire logic pclk,
    input  wire logic open_a,
    input  wire logic open_b,
    output logic      safe_off_input_a,
    output logic      safe_off_input_b
);
    logic [SW_DLY-1:0] a_r = '1;
    logic [SW_DLY-1:0] b_r = '1;
    // contacts settle within SW_DLY cycles, far inside 200 ms
    always @(posedge pclk)
    begin
        a_r <= {a_r[SW_DLY-2:0], !open_a};
        b_r <= {b_r[SW_DLY-2:0], !open_b};
    end
    assign safe_off_input_a = a_r[SW_DLY-1];
    assign safe_off_input_b = b_r[SW_DLY-1];
endmodule : sto_switch_model

// >>> sim/dual_channel_safe_torque_off_test.sv
// self-checking bench for the safe torque off core
`timescale 1ns/1ns
module dual_channel_safe_torque_off_test
    import sto_pkg::*;
;
    localparam int DISC = 20;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic        pready, pslverr, e, a_in, b_in, op_a = 0, op_b = 0, cflt = 0;
    logic [5:0]  gin = '0, gin_d = '0, gout;
    logic        rdy, cst, toi, fa, fb, fc, irq;
    int          err_total = 0, samples_checked = 0;

    always #20 pclk = !pclk;
    always @(posedge pclk)
    begin
        gin <= gin + 6'h1;
        gin_d <= gin;
    end

    sto_switch_model u_sw (.pclk(pclk), .open_a(op_a), .open_b(op_b), .safe_off_input_a(a_in),
        .safe_off_input_b(b_in));
    sto_core #(.PWM_W(6), .DISC_CYC(DISC)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .safe_off_input_a(a_in), .safe_off_input_b(b_in),
        .circuit_fault_in(cflt), .pwm_gate_in(gin), .pwm_gate_out(gout), .drive_ready(rdy),
        .coast_stop(cst), .torque_off_indication(toi), .channel_a_fault_code(fa),
        .channel_b_fault_code(fb), .circuit_fault_code(fc), .irq(irq));

    task chk(input logic [31:0] s, input logic [31:0] x);
        samples_checked++;
        if (s !== x)
        begin
            err_total++;
            $display("wrong value at %0t ns: saw %h want %h", $time, s, x);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : cyc
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        cyc(1);
    endtask : apb
    task end_sim;
        $display("checks %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim

    task t_reset;
        chk(rdy, 0);
        chk(cst, 1);
        apb(0, OFS_CTRL, 0);
        chk(q, 32'h1);
        apb(0, OFS_INT_MASK, 0);
        chk(q, 32'h0);
        apb(1, OFS_CTRL, 32'h3);
        cyc(2);
        chk(rdy, 1);
        chk(gout, gin_d);
        apb(0, 8'h3C, 0);
        chk(e, 1);
        chk(q, 32'h0);
        $display("reset test done");
    endtask : t_reset
    task t_both(input logic auto);
        apb(1, OFS_CTRL, {31'h0, auto});
        op_a <= 1'b1;
        op_b <= 1'b1;
        cyc(8);
        chk({toi, fa, fb, fc, rdy, cst}, 6'h21);
        chk(gout, 6'h00);
        op_a <= 1'b0;
        op_b <= 1'b0;
        cyc(8);
        chk({rdy, toi}, {auto, !auto});
        apb(1, OFS_CTRL, 32'h3);
        cyc(2);
        chk({rdy, toi}, 2'b10);
        $display("torque off test done");
    endtask : t_both
    task t_single(input logic ch);
        apb(1, OFS_INT_STAT, 32'hF);
        apb(1, OFS_INT_MASK, 32'h6);
        if (ch) op_b <= 1'b1;
        else op_a <= 1'b1;
        cyc(DISC + 10);
        chk({fb, fa, toi, rdy}, {ch, !ch, 2'b00});
        apb(0, OFS_FAULT_ST, 0);
        chk(q, ch ? 32'h10 : 32'h01);
        chk(irq, 1);
        apb(1, OFS_INT_STAT, ch ? 32'h4 : 32'h2);
        cyc(2);
        chk(irq, 0);
        op_a <= 1'b0;
        op_b <= 1'b0;
        cyc(8);
        chk({fb | fa, rdy}, 2'b10);
        apb(1, OFS_CTRL, 32'h3);
        cyc(2);
        chk({fb, fa, rdy}, 3'b001);
        $display("single channel test done");
    endtask : t_single
    task t_circuit;
        apb(1, OFS_INT_MASK, 32'h8);
        cflt <= 1'b1;
        cyc(6);
        chk({fc, fa, fb, rdy, irq}, 5'h11);
        chk(gout, 6'h00);
        cflt <= 1'b0;
        cyc(6);
        chk(fc, 1);
        apb(1, OFS_CTRL, 32'h3);
        cyc(2);
        chk({fc, rdy}, 2'b01);
        $display("circuit fault test done");
    endtask : t_circuit

    initial
    begin
        cyc(8);
        presetn <= 1'b1;
        cyc(3);
        t_reset();
        t_both(1);
        t_both(0);
        t_single(0);
        t_single(1);
        t_circuit();
        end_sim();
    end
    initial
    begin
        #200000;
        err_total++;
        end_sim();
    end
endmodule : dual_channel_safe_torque_off_test
